// >>> sec_defs.vh
// constants for the serial eeprom command and protection block
`ifndef SEC_DEFS_VH
`define SEC_DEFS_VH

// opcodes after masking bit 3
`define SEC_OP_MASK       8'hf7
`define SEC_OP_SET_WL     8'h06
`define SEC_OP_CLR_WL     8'h04
`define SEC_OP_RD_STAT    8'h05
`define SEC_OP_WR_STAT    8'h01
`define SEC_OP_RD_ARR     8'h03
`define SEC_OP_WR_ARR     8'h02
`define SEC_OP_RD_ID      8'h83
`define SEC_OP_WR_ID      8'h82

// status byte layout
`define SEC_ST_BUSY       0
`define SEC_ST_WL         1
`define SEC_ST_BPLO       2
`define SEC_ST_BPHI       3
`define SEC_ST_HWPE       7
`define SEC_ST_ALL_BUSY   8'hff

// address fields
`define SEC_ADDR_SEL_BIT  10
`define SEC_LOCK_DATA_BIT 1
`define SEC_BP_QTR_BASE   15'h6000
`define SEC_BP_HALF_BASE  15'h4000

// pin synchroniser order and reset level: {wp_n, si, cs_n, sck}
`define SEC_PIN_SCK       0
`define SEC_PIN_CS        1
`define SEC_PIN_SI        2
`define SEC_PIN_WP        3
`define SEC_PIN_RST       4'hf

// self-timed write cycle
`define SEC_CLK_PERIOD_NS 20
`define SEC_T_WR_NS       5000000

`endif

// >>> sec_command_protect.v
// spi eeprom command decoder, write protection and write-cycle sequencer
`timescale 1ns/10ps
`include "sec_defs.vh"
// What this block does
// - power-up leaves write latch cleared
// - latch clears after disable, status or array write
// - write-enable instruction sets the write latch
// - busy accepts only read-status
// - read-status repeats status byte while selected
// - status write keeps only protect bits
// - status write needs latch, no hardware protection
// - protect bits change only at cycle end
// - protect-enable clears only with pin high
// - array read streams, wraps, stops on deselect
// - array write wraps inside 64-byte page
// - over 64 bytes keeps the last ones
// - protected block untouched; others need latch
// - top address bit ignored for array
// - id read starts at low six bits
// - id read refused while busy
// - id write needs select bit zero
// - lock-status byte bit 0, repeated
// - lock needs deselect at byte boundary
// - lock refused: no latch, all protected, locked
// - sample on rising, shift on falling, msb first
// - decode the eight opcodes, bit 3 ignored
// - block protect selects quarter, half, all
// - status layout; all ones while busy

// shift-register fifo; head word sits in a flip-flop
module sec_fifo #(
    parameter W = 23,
    parameter D = 4,
    parameter AW = 2
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output reg          out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0]  count_reg;
    wire        push;
    wire        pop;
    wire [AW:0] wpos;
    wire [AW:0] count_next;
    integer     i;

    assign in_ready   = (count_reg < D);
    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign wpos       = count_reg - {{AW{1'b0}}, pop};
    assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data   = mem[0];

    // entries slide toward the head on each pop
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            for (i = 0; i < D; i = i + 1) begin
                mem[i] <= {W{1'b0}};
            end
        end else begin
            count_reg <= count_next;
            out_valid <= (count_next != {(AW+1){1'b0}});
            for (i = 0; i < D; i = i + 1) begin
                if (push && (i == wpos)) begin
                    mem[i] <= in_data;
                end else if (pop && (i < D - 1)) begin
                    mem[i] <= mem[i+1];
                end
            end
        end
    end
endmodule

module sec_command_protect #(
    parameter WR_CYCLES = `SEC_T_WR_NS / `SEC_CLK_PERIOD_NS,
    parameter TIMER_W   = 18,
    parameter FIFO_D    = 4
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        sck,
    input  wire        cs_n,
    input  wire        si,
    input  wire        wp_n,
    output reg         so_out,
    output reg         so_oe_n,
    output reg  [14:0] arr_rd_addr,
    input  wire [7:0]  arr_rd_data,
    output wire        arr_wr_valid,
    input  wire        arr_wr_ready,
    output wire [14:0] arr_wr_addr,
    output wire [7:0]  arr_wr_data,
    output reg         busy,
    output reg         write_latch_bit,
    output reg         hw_protect_enable,
    output reg         block_protect_lo,
    output reg         block_protect_hi,
    output reg         id_locked
);
    // serial states, one-hot
    localparam S_IDLE = 6'h01;
    localparam S_CMD  = 6'h02;
    localparam S_ADDR = 6'h04;
    localparam S_WDAT = 6'h08;
    localparam S_RDAT = 6'h10;
    localparam S_SKIP = 6'h20;
    // write cycle states
    localparam W_IDLE  = 3'h1;
    localparam W_DRAIN = 3'h2;
    localparam W_TIMER = 3'h4;
    // read sources and write-cycle kinds
    localparam SRC_STAT = 4'h1;
    localparam SRC_ARR  = 4'h2;
    localparam SRC_ID   = 4'h4;
    localparam SRC_LOCK = 4'h8;
    localparam K_STAT = 4'h1;
    localparam K_ARR  = 4'h2;
    localparam K_ID   = 4'h4;
    localparam K_LOCK = 4'h8;

    // three-flop pin synchronisers plus agreement filter
    reg  [3:0] s1_reg, s2_reg, s3_reg, f_reg, fp_reg;
    wire [3:0] f_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (f_reg & (s2_reg ^ s3_reg));

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= `SEC_PIN_RST;
            s2_reg <= `SEC_PIN_RST;
            s3_reg <= `SEC_PIN_RST;
            f_reg  <= `SEC_PIN_RST;
            fp_reg <= `SEC_PIN_RST;
        end else begin
            s1_reg <= {wp_n, si, cs_n, sck};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            f_reg  <= f_next;
            fp_reg <= f_reg;
        end
    end

    wire sel      = ~f_reg[`SEC_PIN_CS];
    wire cs_fall  = fp_reg[`SEC_PIN_CS] & ~f_reg[`SEC_PIN_CS];
    wire cs_rise  = ~fp_reg[`SEC_PIN_CS] & f_reg[`SEC_PIN_CS];
    wire sck_rise = sel & ~fp_reg[`SEC_PIN_SCK] & f_reg[`SEC_PIN_SCK];
    wire sck_fall = sel & fp_reg[`SEC_PIN_SCK] & ~f_reg[`SEC_PIN_SCK];
    wire si_f     = f_reg[`SEC_PIN_SI];
    wire wp_high  = f_reg[`SEC_PIN_WP];

    reg  [5:0]  st_reg;
    reg  [7:0]  op_reg;
    reg  [7:0]  sh_reg;
    reg  [2:0]  bit_reg;
    reg         abyte_reg;
    reg  [15:0] addr_reg;
    reg  [1:0]  nbyte_reg;
    reg  [2:0]  ocnt_reg;
    reg  [7:0]  osh_reg;
    reg  [3:0]  src_reg;
    reg  [7:0]  stat_data_reg;
    reg  [7:0]  lock_data_reg;
    reg  [8:0]  page_reg;
    reg  [5:0]  ptr_reg;
    reg  [7:0]  pbuf [0:63];
    reg  [63:0] pmask_reg;
    reg  [7:0]  idpg [0:63];
    reg  [2:0]  wst_reg;
    reg  [3:0]  kind_reg;
    reg  [5:0]  idx_reg;
    reg  [TIMER_W-1:0] tmr_reg;
    integer     j;

    wire [7:0]  in_byte = {sh_reg[6:0], si_f};
    wire [7:0]  opm     = in_byte & `SEC_OP_MASK;
    wire [7:0]  opk     = op_reg & `SEC_OP_MASK;
    wire        hw_prot = hw_protect_enable & ~wp_high;
    wire [1:0]  bp      = {block_protect_hi, block_protect_lo};
    wire [14:0] drain_addr = {page_reg, idx_reg};

    // status byte reads all ones during a write cycle
    wire [7:0] stat_byte = busy ? `SEC_ST_ALL_BUSY :
        {hw_protect_enable, 3'h0, block_protect_hi, block_protect_lo, write_latch_bit, 1'b0};

    // protected range by block protect level
    function prot;
        input [14:0] a;
        input [1:0]  lvl;
        begin
            case (lvl)
                2'b01:   prot = (a >= `SEC_BP_QTR_BASE);
                2'b10:   prot = (a >= `SEC_BP_HALF_BASE);
                2'b11:   prot = 1'b1;
                default: prot = 1'b0;
            endcase
        end
    endfunction

    // byte to shift out next, chosen by the active read source
    reg [7:0] out_byte;
    always @* begin
        case (src_reg)
            SRC_STAT: out_byte = stat_byte;
            SRC_ARR:  out_byte = arr_rd_data;
            SRC_ID:   out_byte = idpg[addr_reg[5:0]];
            SRC_LOCK: out_byte = {7'h00, id_locked};
            default:  out_byte = 8'h00;
        endcase
    end

    // array writes never touch the protected block
    wire drain_ok   = pmask_reg[idx_reg] & ~prot(drain_addr, bp);
    wire push_valid = wst_reg[1] & kind_reg[1] & drain_ok;
    wire push_ready;
    wire drain_step = wst_reg[1] & (~push_valid | push_ready);

    sec_fifo #(
        .W  (23),
        .D  (FIFO_D),
        .AW (2)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   ({drain_addr, pbuf[idx_reg]}),
        .out_valid (arr_wr_valid),
        .out_ready (arr_wr_ready),
        .out_data  ({arr_wr_addr, arr_wr_data})
    );

    // serial engine and write-cycle sequencer share the protection state
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg            <= S_IDLE;
            op_reg            <= 8'h00;
            sh_reg            <= 8'h00;
            bit_reg           <= 3'h0;
            abyte_reg         <= 1'b0;
            addr_reg          <= 16'h0000;
            nbyte_reg         <= 2'h0;
            ocnt_reg          <= 3'h0;
            osh_reg           <= 8'h00;
            src_reg           <= SRC_STAT;
            stat_data_reg     <= 8'h00;
            lock_data_reg     <= 8'h00;
            page_reg          <= 9'h000;
            ptr_reg           <= 6'h00;
            pmask_reg         <= 64'h0;
            so_out            <= 1'b0;
            so_oe_n           <= 1'b1;
            arr_rd_addr       <= 15'h0000;
            busy              <= 1'b0;
            write_latch_bit   <= 1'b0;
            hw_protect_enable <= 1'b0;
            block_protect_lo  <= 1'b0;
            block_protect_hi  <= 1'b0;
            id_locked         <= 1'b0;
            wst_reg           <= W_IDLE;
            kind_reg          <= K_STAT;
            idx_reg           <= 6'h00;
            tmr_reg           <= {TIMER_W{1'b0}};
            for (j = 0; j < 64; j = j + 1) begin
                pbuf[j] <= 8'h00;
                idpg[j] <= 8'h00;
            end
        end else begin
            // frame start
            if (cs_fall) begin
                st_reg    <= S_CMD;
                bit_reg   <= 3'h0;
                nbyte_reg <= 2'h0;
                abyte_reg <= 1'b0;
                ocnt_reg  <= 3'h0;
            end else if (cs_rise) begin
                st_reg  <= S_IDLE;
                so_oe_n <= 1'b1;
                // operations start only on a deselect at a byte boundary
                if (st_reg[3] && (bit_reg == 3'h0)) begin
                    case (opk)
                        `SEC_OP_SET_WL: write_latch_bit <= 1'b1;
                        `SEC_OP_CLR_WL: write_latch_bit <= 1'b0;
                        `SEC_OP_WR_STAT: begin
                            if ((nbyte_reg != 2'h0) && write_latch_bit && !hw_prot) begin
                                busy     <= 1'b1;
                                kind_reg <= K_STAT;
                                wst_reg  <= W_TIMER;
                                tmr_reg  <= {TIMER_W{1'b0}};
                            end
                        end
                        `SEC_OP_WR_ARR: begin
                            // outside the block the latch must be set
                            if ((nbyte_reg != 2'h0) && write_latch_bit) begin
                                busy     <= 1'b1;
                                kind_reg <= K_ARR;
                                wst_reg  <= W_DRAIN;
                                idx_reg  <= 6'h00;
                            end
                        end
                        `SEC_OP_WR_ID: begin
                            if (!addr_reg[`SEC_ADDR_SEL_BIT]) begin
                                if ((nbyte_reg != 2'h0) && write_latch_bit && !id_locked) begin
                                    busy     <= 1'b1;
                                    kind_reg <= K_ID;
                                    wst_reg  <= W_DRAIN;
                                    idx_reg  <= 6'h00;
                                end
                            end else if ((nbyte_reg == 2'h1) && write_latch_bit &&
                                         (bp != 2'b11) && !id_locked &&
                                         lock_data_reg[`SEC_LOCK_DATA_BIT]) begin
                                // exactly one data byte then deselect
                                busy     <= 1'b1;
                                kind_reg <= K_LOCK;
                                wst_reg  <= W_TIMER;
                                tmr_reg  <= {TIMER_W{1'b0}};
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (sck_rise && (st_reg[1] || st_reg[2] || st_reg[3])) begin
                // msb-first sampling on rising clock
                sh_reg  <= in_byte;
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    if (st_reg[1]) begin
                        op_reg <= in_byte;
                        if (busy && (opm != `SEC_OP_RD_STAT)) begin
                            st_reg <= S_SKIP;
                        end else begin
                            case (opm)
                                `SEC_OP_SET_WL, `SEC_OP_CLR_WL, `SEC_OP_WR_STAT:
                                    st_reg <= S_WDAT;
                                `SEC_OP_RD_STAT: begin
                                    st_reg  <= S_RDAT;
                                    src_reg <= SRC_STAT;
                                end
                                `SEC_OP_RD_ARR, `SEC_OP_WR_ARR, `SEC_OP_RD_ID, `SEC_OP_WR_ID:
                                    st_reg <= S_ADDR;
                                default: st_reg <= S_SKIP;
                            endcase
                        end
                    end else if (st_reg[2]) begin
                        abyte_reg <= 1'b1;
                        if (!abyte_reg) begin
                            addr_reg[15:8] <= in_byte;
                        end else begin
                            addr_reg[7:0] <= in_byte;
                            ptr_reg       <= in_byte[5:0];
                            page_reg      <= {addr_reg[14:8], in_byte[7:6]};
                            arr_rd_addr   <= {addr_reg[14:8], in_byte};
                            case (opk)
                                `SEC_OP_RD_ARR: begin
                                    st_reg  <= S_RDAT;
                                    src_reg <= SRC_ARR;
                                end
                                `SEC_OP_RD_ID: begin
                                    st_reg  <= S_RDAT;
                                    src_reg <= addr_reg[`SEC_ADDR_SEL_BIT] ? SRC_LOCK : SRC_ID;
                                end
                                default: begin
                                    st_reg    <= S_WDAT;
                                    pmask_reg <= 64'h0;
                                end
                            endcase
                        end
                    end else begin
                        if (nbyte_reg != 2'h2) begin
                            nbyte_reg <= nbyte_reg + 2'h1;
                        end
                        // only the protect bits are kept, first byte wins
                        if (nbyte_reg == 2'h0) begin
                            stat_data_reg <= in_byte;
                        end
                        lock_data_reg <= in_byte;
                        if ((opk == `SEC_OP_WR_ARR) ||
                            ((opk == `SEC_OP_WR_ID) && !addr_reg[`SEC_ADDR_SEL_BIT])) begin
                            // later bytes overwrite earlier ones at the same slot
                            pbuf[ptr_reg]      <= in_byte;
                            pmask_reg[ptr_reg] <= 1'b1;
                            ptr_reg            <= ptr_reg + 6'h01;
                        end
                    end
                end
            end else if (sck_fall && st_reg[4]) begin
                // shift out on falling clock, repeat or advance per byte
                so_oe_n  <= 1'b0;
                ocnt_reg <= ocnt_reg + 3'h1;
                if (ocnt_reg == 3'h0) begin
                    so_out  <= out_byte[7];
                    osh_reg <= {out_byte[6:0], 1'b0};
                    if (src_reg == SRC_ARR) begin
                        arr_rd_addr <= arr_rd_addr + 15'h0001;
                    end
                    if (src_reg == SRC_ID) begin
                        addr_reg[5:0] <= addr_reg[5:0] + 6'h01;
                    end
                end else begin
                    so_out  <= osh_reg[7];
                    osh_reg <= {osh_reg[6:0], 1'b0};
                end
            end

            // write-cycle sequencer; nothing above starts one while busy
            case (wst_reg)
                W_DRAIN: begin
                    if (drain_step) begin
                        if (kind_reg[2] && pmask_reg[idx_reg]) begin
                            idpg[idx_reg] <= pbuf[idx_reg];
                        end
                        idx_reg <= idx_reg + 6'h01;
                        if (idx_reg == 6'h3f) begin
                            wst_reg <= W_TIMER;
                            tmr_reg <= {TIMER_W{1'b0}};
                        end
                    end
                end
                W_TIMER: begin
                    if (tmr_reg != WR_CYCLES[TIMER_W-1:0] - 1'b1) begin
                        tmr_reg <= tmr_reg + 1'b1;
                    end else if (!arr_wr_valid) begin
                        // results become visible only now
                        wst_reg         <= W_IDLE;
                        busy            <= 1'b0;
                        write_latch_bit <= 1'b0;
                        if (kind_reg[0]) begin
                            block_protect_lo  <= stat_data_reg[`SEC_ST_BPLO];
                            block_protect_hi  <= stat_data_reg[`SEC_ST_BPHI];
                            // no 1-to-0 while the pin is low
                            hw_protect_enable <= (hw_protect_enable & ~wp_high) |
                                                 stat_data_reg[`SEC_ST_HWPE];
                        end
                        if (kind_reg[3]) begin
                            id_locked <= 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
    end
endmodule

// >>> sec_command_protect_props.sv
// concurrent checks on the ports of the eeprom command and protection block
`timescale 1ns/10ps
module sec_command_protect_props (
    input wire        clk,
    input wire        resetn,
    input wire        cs_n,
    input wire        wp_n,
    input wire        so_oe_n,
    input wire        arr_wr_valid,
    input wire        arr_wr_ready,
    input wire [14:0] arr_wr_addr,
    input wire [7:0]  arr_wr_data,
    input wire        busy,
    input wire        write_latch_bit,
    input wire        hw_protect_enable,
    input wire        block_protect_lo,
    input wire        block_protect_hi,
    input wire        id_locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // six cycles covers the pin synchroniser delay after deselect
    a_oe_released: assert property (cs_n [*6] |-> so_oe_n)
        else $error("serial output driven while deselected");
    a_oe_selected: assert property ($fell(so_oe_n) |-> !cs_n)
        else $error("serial output enabled without chip select");
    a_wr_hold: assert property (arr_wr_valid && !arr_wr_ready |=>
        arr_wr_valid && $stable(arr_wr_addr) && $stable(arr_wr_data))
        else $error("array word changed while stalled");
    a_busy_drain: assert property ($fell(busy) |-> !arr_wr_valid)
        else $error("write cycle ended with words pending");
    a_busy_min: assert property ($rose(busy) |=> busy [*8])
        else $error("write cycle too short");
    a_prot_steady: assert property (busy && $past(busy) |-> $stable(block_protect_lo)
        && $stable(block_protect_hi) && $stable(hw_protect_enable))
        else $error("protect bits changed inside write cycle");
    a_lock_keep: assert property (id_locked |=> id_locked)
        else $error("id page lock released");
    a_lock_end: assert property ($rose(id_locked) |-> $past(busy))
        else $error("lock set without write cycle");
    a_latch_idle: assert property ($rose(write_latch_bit) |-> !busy)
        else $error("write latch set while busy");
    a_hwpe_drop: assert property ($fell(hw_protect_enable) |-> wp_n)
        else $error("protect enable cleared with pin low");
endmodule

bind sec_command_protect sec_command_protect_props i_props (.clk(clk), .resetn(resetn),
    .cs_n(cs_n), .wp_n(wp_n), .so_oe_n(so_oe_n), .arr_wr_valid(arr_wr_valid),
    .arr_wr_ready(arr_wr_ready), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data),
    .busy(busy), .write_latch_bit(write_latch_bit), .hw_protect_enable(hw_protect_enable),
    .block_protect_lo(block_protect_lo), .block_protect_hi(block_protect_hi),
    .id_locked(id_locked));

// >>> sec_spi_host.sv
// spi host model driving chip select, clock and data bit by bit
`timescale 1ns/10ps
module sec_spi_host (
    input  wire  clk,
    output logic sck,
    output logic cs_n,
    output logic si,
    input  wire  so_out
);
    logic [7:0] rx_q[$];

    // idle clock low and stands still between frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // every phase lasts at least 6 clk so the device filter sees each level
    task automatic xfer(input logic [7:0] tx[$]);
        logic [7:0] b;
        rx_q = {};
        @(posedge clk) cs_n <= 1'b0;
        repeat (6) @(posedge clk);
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                si <= tx[i][k]; // msb first
                repeat (6) @(posedge clk);
                sck <= 1'b1;
                b[k] = so_out; // settled since the last falling edge
                repeat (6) @(posedge clk);
                sck <= 1'b0;
            end
            rx_q.push_back(b);
        end
        repeat (6) @(posedge clk);
        cs_n <= 1'b1; // deselect at a byte boundary
        si <= ~si; // no stale level after release
        repeat (10) @(posedge clk);
    endtask
endmodule

// >>> sec_command_protect_tb.sv
// self-checking bench for the eeprom command and protection block
`timescale 1ns/10ps
module sec_command_protect_tb;
    logic       clk, resetn, wp_n, arr_wr_ready;
    wire        sck, cs_n, si, so_out, so_oe_n, arr_wr_valid, busy, write_latch_bit;
    wire        hw_protect_enable, block_protect_lo, block_protect_hi, id_locked;
    wire [14:0] arr_rd_addr, arr_wr_addr;
    wire [7:0]  arr_wr_data;
    logic [7:0] mem [0:32767];
    logic [7:0] v;
    int         num_errors = 0;
    int         num_checks = 0;
    wire [7:0]  arr_rd_data = mem[arr_rd_addr];

    sec_command_protect #(.WR_CYCLES(20)) i_dut (.clk(clk), .resetn(resetn), .sck(sck),
        .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n),
        .arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data), .arr_wr_valid(arr_wr_valid),
        .arr_wr_ready(arr_wr_ready), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data),
        .busy(busy), .write_latch_bit(write_latch_bit), .hw_protect_enable(hw_protect_enable),
        .block_protect_lo(block_protect_lo), .block_protect_hi(block_protect_hi),
        .id_locked(id_locked));
    // released serial output reads as its pull-up level
    sec_spi_host i_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si),
        .so_out(so_oe_n ? 1'b1 : so_out));

    // array model takes a word on each accepted edge
    always @(posedge clk) begin
        if (arr_wr_valid && arr_wr_ready) mem[arr_wr_addr] <= arr_wr_data;
    end

    function automatic logic [7:0] pat(input int a);
        return a[7:0] ^ 8'h3c;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // bounded wait for the self-timed cycle to finish
    task automatic wait_idle;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
        chk({7'h00, busy}, 8'h00, "write cycle hung");
    endtask

    task automatic rd_st(output logic [7:0] s);
        i_host.xfer('{8'h05, 8'h00, 8'h00});
        chk(i_host.rx_q[2], i_host.rx_q[1], "status not repeated");
        s = i_host.rx_q[1];
    endtask

    task automatic t_power;
        rd_st(v); chk(v, 8'h00, "power-up status");
        i_host.xfer('{8'h40, 8'h00}); chk(i_host.rx_q[1], 8'hff, "released");
        rd_st(v); chk(v, 8'h00, "unknown opcode");
        i_host.xfer('{8'h0e}); rd_st(v); chk(v, 8'h02, "latch set");
        i_host.xfer('{8'h0c}); rd_st(v); chk(v, 8'h00, "latch cleared");
        i_host.xfer('{8'h02, 8'h00, 8'h10, 8'haa}); // no latch, no write
        chk({7'h00, busy}, 8'h00, "write ran without latch");
        chk(mem[16], pat(16), "unlatched write");
    endtask

    task automatic t_read;
        i_host.xfer('{8'h03, 8'hff, 8'hff, 8'h00, 8'h00});
        chk(i_host.rx_q[3], pat(32767), "last byte");
        chk(i_host.rx_q[4], pat(0), "read wrap");
    endtask

    // six bytes from slot 3c fill the stalled fifo and wrap in the page
    task automatic t_page;
        i_host.xfer('{8'h06});
        @(posedge clk) arr_wr_ready <= 1'b0;
        i_host.xfer('{8'h02, 8'h80, 8'h3c, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15});
        rd_st(v); chk(v, 8'hff, "busy status");
        i_host.xfer('{8'h83, 8'h00, 8'h05, 8'h00});
        chk(i_host.rx_q[3], 8'hff, "id read while busy");
        @(posedge clk) arr_wr_ready <= 1'b1;
        wait_idle;
        for (int i = 0; i < 6; i++) chk(mem[(60 + i) % 64], 8'h10 + i, "page data");
        rd_st(v); chk(v, 8'h00, "latch after write");
    endtask

    task automatic t_status;
        i_host.xfer('{8'h06}); i_host.xfer('{8'h01, 8'hff}); wait_idle;
        rd_st(v); chk(v, 8'h8c, "status write");
        i_host.xfer('{8'h06}); i_host.xfer('{8'h02, 8'h01, 8'h00, 8'h77}); wait_idle;
        chk(mem[256], pat(256), "protected write");
        @(posedge clk) wp_n <= 1'b0;
        i_host.xfer('{8'h06}); i_host.xfer('{8'h01, 8'h00});
        rd_st(v); chk(v, 8'h8e, "hw protected status write");
        @(posedge clk) wp_n <= 1'b1;
        i_host.xfer('{8'h01, 8'h00}); wait_idle;
        rd_st(v); chk(v, 8'h00, "protect enable cleared");
    endtask

    task automatic t_id;
        i_host.xfer('{8'h06}); i_host.xfer('{8'h82, 8'h00, 8'h05, 8'ha5, 8'h5a}); wait_idle;
        i_host.xfer('{8'h83, 8'h00, 8'h05, 8'h00, 8'h00});
        chk(i_host.rx_q[3], 8'ha5, "id byte");
        chk(i_host.rx_q[4], 8'h5a, "id next byte");
        i_host.xfer('{8'h06}); i_host.xfer('{8'h82, 8'h04, 8'h00, 8'h02}); wait_idle;
        i_host.xfer('{8'h83, 8'h04, 8'h00, 8'h00, 8'h00});
        chk(i_host.rx_q[4], 8'h01, "lock status");
        i_host.xfer('{8'h06}); i_host.xfer('{8'h82, 8'h00, 8'h05, 8'h00}); wait_idle;
        i_host.xfer('{8'h83, 8'h00, 8'h05, 8'h00});
        chk(i_host.rx_q[3], 8'ha5, "locked page written");
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // roughly 10k clk expected, limit allows 100k
    initial begin
        #2000000;
        num_errors++;
        report_and_stop;
    end

    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = pat(i);
        resetn = 1'b0;
        wp_n = 1'b1;
        arr_wr_ready = 1'b1;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        t_power;
        t_read;
        t_page;
        t_status;
        t_id;
        report_and_stop;
    end
endmodule
